// ---- dcl_map.vh ----
`ifndef DCL_MAP_VH
`define DCL_MAP_VH
// ************************************
// register byte addresses
// ************************************
`define DCL_ADDR_STATUS 4'h0
`define DCL_ADDR_CONTROL 4'h4
`define DCL_ADDR_CONFIG 4'h8
// ************************************
// status / control field positions
// ************************************
`define DCL_BIT_IN_RESET 15
`define DCL_BIT_WDT_RESET 14
`define DCL_BIT_PWR_HI 13
`define DCL_BIT_PWR_LO 12
`define DCL_BIT_VERIFY_ERR 11
`define DCL_BIT_PANEL2 10
`define DCL_BIT_REQUEST 9
`define DCL_BIT_ACK 8
`define DCL_BIT_DEBUG 7
`define DCL_PTR_HI 6
`define DCL_PTR_LO 0
// config register fields
`define DCL_CFG_ENABLE 0
`define DCL_CFG_ON_PRIMARY 1
`define DCL_CFG_ON_SECONDARY 2
// ************************************
// encodings
// ************************************
`define DCL_PWR_NONE 2'h0
`define DCL_PWR_IDLE 2'h1
`define DCL_PWR_SLEEP 2'h2
`define DCL_RESP_OKAY 2'h0
`define DCL_RESP_SLVERR 2'h2
`define DCL_PTR_ZERO 7'h00
`define DCL_WORD_ZERO 32'h00000000
`endif

// ---- dcl_reset_ctrl.v ----
`include "dcl_map.vh"
// ************************************
// secondary reset and enable truth table
// ************************************
module dcl_reset_ctrl (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // reset sources, already synchronised
  input wire por_bor_clr,
  input wire primary_rt_reset,
  input wire secondary_rt_reset,
  input wire secondary_wdt_reset,
  input wire app_mode,
  // options
  input wire reset_on_primary_option,
  input wire reset_on_secondary_option,
  // enable set by software
  input wire enable_set,
  input wire enable_clr,
  // results
  output wire secondary_reset_now,
  output reg secondary_enable_reg
);
  wire sec_src;
  wire disable_evt;
  // secondary sources include por/bor/clear in application mode
  assign sec_src = secondary_rt_reset | secondary_wdt_reset | (por_bor_clr & app_mode); // (R13)
  // por/bor/clear and primary resets always hold the secondary when the table resets it
  assign secondary_reset_now = sec_src | por_bor_clr |
    (primary_rt_reset & ~(reset_on_secondary_option & ~reset_on_primary_option)); // (R13)
  // which resets also disable
  assign disable_evt = por_bor_clr | // (R9)
    (reset_on_secondary_option & sec_src) | // (R10)
    (reset_on_secondary_option & reset_on_primary_option & primary_rt_reset); // (R11)
  // disable wins over a simultaneous software enable, the core is in reset anyway
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      secondary_enable_reg <= 1'b0;
    end else if (disable_evt | enable_clr) begin
      secondary_enable_reg <= 1'b0;
    end else if (enable_set) begin
      secondary_enable_reg <= 1'b1; // (R12)
    end
  end
endmodule // dcl_reset_ctrl

// ---- dcl_link.v ----
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`include "dcl_map.vh"
// Overview of operation
// (R1) bit 15 shows secondary in reset; its rise interrupts primary when request set
// (R2) watchdog reset sets bit 14 together with the general reset bit
// (R3) bits 13-12 show power: 10 sleep, 01 idle, 00 running
// (R4) bit 11 set on verify error during program-RAM write verify
// (R5) primary requests secondary interrupt with control bit 9
// (R6) secondary requests primary interrupt via status bit 9
// (R7) bit 8 in status and control acknowledges the opposite request
// (R8) bit 7 shows secondary debug mode
// (R9) option off: power-on, brown-out, clear reset and disable secondary
// (R10) secondary option only: secondary resets disable, primary resets ignored
// (R11) both options set: any secondary or primary reset disables
// (R12) primary re-enables secondary after a disabling reset
// (R13) secondary sources include application-mode power-on, brown-out, clear resets
// (R14) seven-bit fifo pointers at bits 6:0, readable only in debug
// (R15) request holds until acknowledge; four-phase handshake
module dcl_link (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // device reset sources, asynchronous pins
  input wire por_bor_clr,
  input wire primary_rt_reset,
  input wire secondary_rt_reset,
  input wire secondary_wdt_reset,
  // secondary core state, asynchronous
  input wire secondary_sleep,
  input wire secondary_idle,
  input wire secondary_debug_flag,
  input wire secondary_app_mode,
  input wire secondary_ram_verify_instr,
  input wire verify_mismatch,
  input wire secondary_panel_two_active,
  // secondary side handshake, asynchronous
  input wire sec_to_pri_request,
  input wire pri_to_sec_ack,
  input wire [6:0] write_fifo_pointer,
  input wire [6:0] read_fifo_pointer,
  // outputs toward secondary and primary
  output wire pri_to_sec_request,
  output wire sec_to_pri_ack,
  output wire secondary_in_reset,
  output wire secondary_enable,
  output reg reset_event_irq
);
  localparam NSYNC = 13;
  localparam PW = 7;
  localparam NPTR = 2;
  // positions of each level in the synchroniser vector
  localparam SY_S2P_REQ = 12;
  localparam SY_P2S_ACK = 11;
  localparam SY_MISMATCH = 10;
  localparam SY_VERIFY = 9;
  localparam SY_APP = 8;
  localparam SY_DEBUG = 7;
  localparam SY_IDLE = 6;
  localparam SY_SLEEP = 5;
  localparam SY_WDT = 4;
  localparam SY_SEC_RT = 3;
  localparam SY_PRI_RT = 2;
  localparam SY_PBC = 1;
  localparam SY_PANEL2 = 0;
  // ************************************
  // two-flop synchronisers for all asynchronous inputs
  // ************************************
  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] meta_reg;
  reg [NSYNC-1:0] sync_reg;
  wire [6:0] wptr_s;
  wire [6:0] rptr_s;
  // packed in the order of the positions above
  assign async_in = {sec_to_pri_request, pri_to_sec_ack, verify_mismatch, secondary_ram_verify_instr,
    secondary_app_mode, secondary_debug_flag, secondary_idle, secondary_sleep, secondary_wdt_reset,
    secondary_rt_reset, primary_rt_reset, por_bor_clr, secondary_panel_two_active};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      // each bit synchronised alone; no bit relies on another for timing
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= async_in[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate
  wire s_s2p_req = sync_reg[SY_S2P_REQ];
  wire s_p2s_ack = sync_reg[SY_P2S_ACK];
  wire s_mismatch = sync_reg[SY_MISMATCH];
  wire s_verify = sync_reg[SY_VERIFY];
  wire s_app = sync_reg[SY_APP];
  wire s_debug = sync_reg[SY_DEBUG];
  wire s_idle = sync_reg[SY_IDLE];
  wire s_sleep = sync_reg[SY_SLEEP];
  wire s_wdt = sync_reg[SY_WDT];
  wire s_sec_rt = sync_reg[SY_SEC_RT];
  wire s_pri_rt = sync_reg[SY_PRI_RT];
  wire s_pbc = sync_reg[SY_PBC];
  wire s_panel2 = sync_reg[SY_PANEL2];
  // pointer words: synchronised, then taken only when two samples agree
  wire [NPTR*PW-1:0] ptr_in;
  reg [NPTR*PW-1:0] ptr_meta_reg;
  reg [NPTR*PW-1:0] ptr_sync_reg;
  reg [NPTR*PW-1:0] ptr_prev_reg;
  reg [NPTR*PW-1:0] ptr_hold_reg;
  assign ptr_in = {read_fifo_pointer, write_fifo_pointer};
  genvar gp;
  generate
    for (gp = 0; gp < NPTR; gp = gp + 1) begin : g_ptr
      // a word caught while its bits move never shows; costs two cycles of latency
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ptr_meta_reg[gp*PW +: PW] <= `DCL_PTR_ZERO;
          ptr_sync_reg[gp*PW +: PW] <= `DCL_PTR_ZERO;
          ptr_prev_reg[gp*PW +: PW] <= `DCL_PTR_ZERO;
          ptr_hold_reg[gp*PW +: PW] <= `DCL_PTR_ZERO;
        end else begin
          ptr_meta_reg[gp*PW +: PW] <= ptr_in[gp*PW +: PW];
          ptr_sync_reg[gp*PW +: PW] <= ptr_meta_reg[gp*PW +: PW];
          ptr_prev_reg[gp*PW +: PW] <= ptr_sync_reg[gp*PW +: PW];
          if (ptr_sync_reg[gp*PW +: PW] == ptr_prev_reg[gp*PW +: PW]) begin
            ptr_hold_reg[gp*PW +: PW] <= ptr_prev_reg[gp*PW +: PW];
          end
        end
      end
    end
  endgenerate
  // write pointer sits in the low slice, read pointer above it
  assign wptr_s = ptr_hold_reg[PW-1:0];
  assign rptr_s = ptr_hold_reg[NPTR*PW-1:PW];
  // ************************************
  // axi4-lite handshakes
  // ************************************
  reg aw_full_reg;
  reg w_full_reg;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire aw_take;
  wire w_take;
  wire wr_go;
  wire rd_go;
  wire aw_mapped;
  // one write at a time: no new address or data until the response leaves
  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_go = aw_full_reg & w_full_reg;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  // status writes are answered okay and dropped; anything off the map is an error
  assign aw_mapped = aw_addr_reg == `DCL_ADDR_CONTROL || aw_addr_reg == `DCL_ADDR_CONFIG ||
    aw_addr_reg == `DCL_ADDR_STATUS;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= `DCL_WORD_ZERO;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCL_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_mapped ? `DCL_RESP_OKAY : `DCL_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ************************************
  // control and config registers
  // ************************************
  reg req_reg;
  reg ack_reg;
  reg opt_pri_reg;
  reg opt_sec_reg;
  wire wr_ctl;
  wire wr_cfg;
  wire en_set;
  wire en_clr;
  assign wr_ctl = wr_go && aw_addr_reg == `DCL_ADDR_CONTROL && w_strb_reg[1];
  assign wr_cfg = wr_go && aw_addr_reg == `DCL_ADDR_CONFIG && w_strb_reg[0];
  assign en_set = wr_cfg & w_data_reg[`DCL_CFG_ENABLE];
  assign en_clr = wr_cfg & ~w_data_reg[`DCL_CFG_ENABLE];
  // request and ack bits are plain software bits; the four-phase order is kept by software
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_reg <= 1'b0;
      ack_reg <= 1'b0;
      opt_pri_reg <= 1'b1; // unprogrammed default
      opt_sec_reg <= 1'b1;
    end else begin
      if (wr_ctl) begin
        req_reg <= w_data_reg[`DCL_BIT_REQUEST]; // (R5)
        ack_reg <= w_data_reg[`DCL_BIT_ACK]; // (R7)
      end
      if (wr_cfg) begin
        opt_pri_reg <= w_data_reg[`DCL_CFG_ON_PRIMARY];
        opt_sec_reg <= w_data_reg[`DCL_CFG_ON_SECONDARY];
      end
    end
  end
  assign pri_to_sec_request = req_reg; // (R15)
  assign sec_to_pri_ack = ack_reg; // (R15)
  // ************************************
  // secondary reset control
  // ************************************
  wire rst_now;
  dcl_reset_ctrl u_rst (
    .clk(clk),
    .rst_b(rst_b),
    .por_bor_clr(s_pbc),
    .primary_rt_reset(s_pri_rt),
    .secondary_rt_reset(s_sec_rt),
    .secondary_wdt_reset(s_wdt),
    .app_mode(s_app),
    .reset_on_primary_option(opt_pri_reg),
    .reset_on_secondary_option(opt_sec_reg),
    .enable_set(en_set),
    .enable_clr(en_clr),
    .secondary_reset_now(rst_now),
    .secondary_enable_reg(secondary_enable)
  );
  // ************************************
  // status bits
  // ************************************
  reg in_reset_reg;
  reg wdt_flag_reg;
  reg verify_err_reg;
  reg [1:0] power_state_next;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_reset_reg <= 1'b0;
      wdt_flag_reg <= 1'b0;
      verify_err_reg <= 1'b0;
      reset_event_irq <= 1'b0;
    end else begin
      // in-reset follows the combined sources one edge later
      in_reset_reg <= rst_now; // (R1)
      // pulse on the leading edge of reset while a request is pending
      reset_event_irq <= rst_now & ~in_reset_reg & req_reg; // (R1)
      // the cause is kept until a reset of another kind, so software can read it afterwards
      if (s_wdt) begin
        wdt_flag_reg <= 1'b1; // (R2)
      end else if (rst_now & ~in_reset_reg) begin
        wdt_flag_reg <= 1'b0; // a non-watchdog reset replaces the cause
      end
      // error follows each verify instruction's result
      if (s_verify) begin
        verify_err_reg <= s_mismatch; // (R4)
      end
    end
  end
  assign secondary_in_reset = in_reset_reg;
  // sleep takes priority; both together never leave the reserved code
  always @* begin
    if (s_sleep) begin
      power_state_next = `DCL_PWR_SLEEP; // (R3)
    end else if (s_idle) begin
      power_state_next = `DCL_PWR_IDLE; // (R3)
    end else begin
      power_state_next = `DCL_PWR_NONE; // (R3)
    end
  end
  wire [15:0] status_word;
  wire [15:0] control_word;
  // the watchdog feeds the reset path, so bit 15 rises with bit 14 yet falls when the reset ends
  assign status_word = {in_reset_reg, wdt_flag_reg, power_state_next, verify_err_reg, // (R1) (R2)
    s_panel2, s_s2p_req, s_p2s_ack, s_debug, // (R6) (R7) (R8)
    s_debug ? wptr_s : `DCL_PTR_ZERO}; // (R14)
  // control keeps bit 7 empty; request and ack sit at 9 and 8
  assign control_word = {6'h00, req_reg, ack_reg, 1'b0, s_debug ? rptr_s : `DCL_PTR_ZERO}; // (R14)
  // ************************************
  // read channel
  // ************************************
  // answer on the same edge that takes the address; data stand until rready
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `DCL_WORD_ZERO;
      s_axi_rresp <= `DCL_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DCL_RESP_OKAY;
      case (s_axi_araddr)
        `DCL_ADDR_STATUS: begin
          s_axi_rdata <= {16'h0000, status_word};
        end
        `DCL_ADDR_CONTROL: begin
          s_axi_rdata <= {16'h0000, control_word};
        end
        `DCL_ADDR_CONFIG: begin
          // bit 0 enable, bit 1 primary option, bit 2 secondary option
          s_axi_rdata <= {29'h0000000, opt_sec_reg, opt_pri_reg, secondary_enable};
        end
        default: begin
          s_axi_rdata <= `DCL_WORD_ZERO;
          s_axi_rresp <= `DCL_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // dcl_link

// ---- dcl_link_monitor.sv ----
module dcl_link_monitor (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // bus handshakes
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // link outputs
  input wire pri_to_sec_request,
  input wire secondary_in_reset,
  input wire secondary_enable,
  input wire reset_event_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ************************************
  // bus responses
  // ************************************
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read accepted while answer pending");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write accepted while answer pending");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  // ************************************
  // link behaviour
  // ************************************
  property p_irq_pulse; reset_event_irq |=> !reset_event_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("reset event not a pulse");
  property p_irq_cause;
    reset_event_irq |-> (secondary_in_reset || $past(secondary_in_reset))
      && (pri_to_sec_request || $past(pri_to_sec_request));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("reset event without cause");
  // software owns the request bit: it moves only with a write answer
  property p_req_sw; $changed(pri_to_sec_request) |-> s_axi_bvalid; endproperty
  a_req_sw: assert property (p_req_sw) else $error("request moved without write");
  property p_en_drop; $fell(secondary_enable) |-> ##[0:1] (secondary_in_reset || s_axi_bvalid); endproperty
  a_en_drop: assert property (p_en_drop) else $error("enable lost without cause");
endmodule // dcl_link_monitor

bind dcl_link dcl_link_monitor u_mon (.clk(clk), .rst_b(rst_b), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pri_to_sec_request(pri_to_sec_request), .secondary_in_reset(secondary_in_reset),
  .secondary_enable(secondary_enable), .reset_event_irq(reset_event_irq));

// ---- dcl_sec_model.sv ----
module dcl_sec_model (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // bench control
  input wire raise_req,
  input wire [3:0] ack_delay,
  // link wires
  input wire pri_to_sec_request,
  input wire sec_to_pri_ack,
  output logic sec_to_pri_request,
  output logic pri_to_sec_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  // acknowledge after a delay so slow answers are exercised too
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 4'h0;
      pri_to_sec_ack <= 1'h0;
    end else if (!pri_to_sec_request) begin
      wait_cnt <= 4'h0;
      pri_to_sec_ack <= 1'h0;
    end else if (wait_cnt == ack_delay) begin
      pri_to_sec_ack <= 1'h1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  // own request holds until the primary acknowledges
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) sec_to_pri_request <= 1'h0;
    else if (sec_to_pri_ack) sec_to_pri_request <= 1'h0;
    else if (raise_req) sec_to_pri_request <= 1'h1;
  end
endmodule // dcl_sec_model

// ---- dcl_tb.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, held, dis;
  logic [3:0] awaddr, araddr, wstrb, ack_delay;
  logic [31:0] wdata, rd;
  logic [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic por, pri_rt, sec_rt, wdt, slp, idl, dbg, app, vin, vmis, pan, raise_req;
  logic [6:0] wptr, rptr;
  wire s2p_req, p2s_ack, p2s_req, s2p_ack, in_rst, sec_en, irq;
  int n_mismatch = 0, n_tests = 0, cycles = 0, n_irq = 0, exp_irq = 0;
  dcl_link uut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .por_bor_clr(por),
    .primary_rt_reset(pri_rt), .secondary_rt_reset(sec_rt), .secondary_wdt_reset(wdt),
    .secondary_sleep(slp), .secondary_idle(idl), .secondary_debug_flag(dbg), .secondary_app_mode(app),
    .secondary_ram_verify_instr(vin), .verify_mismatch(vmis), .secondary_panel_two_active(pan),
    .sec_to_pri_request(s2p_req), .pri_to_sec_ack(p2s_ack), .write_fifo_pointer(wptr),
    .read_fifo_pointer(rptr), .pri_to_sec_request(p2s_req), .sec_to_pri_ack(s2p_ack),
    .secondary_in_reset(in_rst), .secondary_enable(sec_en), .reset_event_irq(irq));
  dcl_sec_model u_sec (.clk(clk), .rst_b(rst_b), .raise_req(raise_req), .ack_delay(ack_delay),
    .pri_to_sec_request(p2s_req), .sec_to_pri_ack(s2p_ack), .sec_to_pri_request(s2p_req),
    .pri_to_sec_ack(p2s_ack));
  // ************************************
  // clock, watchdog and event count
  // ************************************
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (irq === 1'h1) n_irq <= n_irq + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ************************************
  // tasks
  // ************************************
  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rs = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  task automatic chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_reg(a);
    check(rd & m, e);
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, raise_req} = '0;
    {por, pri_rt, sec_rt, wdt, slp, idl, app, vmis, vin} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    ack_delay = 4'h3;
    dbg = 1'h1;
    pan = 1'h1;
    wptr = 7'h55;
    rptr = 7'h2A;
    rst_b = 1'h0;
    cyc(6);
    rst_b <= 1'h1;
    chk(4'h8, 32'hFFFFFFFF, 32'h6);
    chk(4'hC, 32'hFFFFFFFF, 32'h0);
    check(rs, 32'h2);
    wr(4'h0, 32'hFFFF);
    check(rs, 32'h0);
    // sleep wins over idle in the last pass
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {slp, idl} <= i[1:0];
      vin <= 1'h1;
      vmis <= 1'h1;
      cyc(5);
      chk(4'h0, 32'hFFFF3CFF, {i[1], !i[1] && i[0], 2'h3, 10'hD5} << 10 >> 10 | (i[1] ? 32'h2000 : 32'h0)
        | (!i[1] && i[0] ? 32'h1000 : 32'h0) | 32'hCD5);
      chk(4'h4, 32'hFFFF007F, 32'h2A);
    end
    @(posedge clk);
    dbg <= 1'h0;
    vmis <= 1'h0;
    cyc(5);
    chk(4'h0, 32'h3CFF, 32'h2400);
    chk(4'h4, 32'h7F, 32'h0);
    wr(4'h4, 32'h200);
    cyc(8);
    check(p2s_req, 32'h1);
    chk(4'h0, 32'h100, 32'h100);
    wr(4'h4, 32'h0);
    cyc(6);
    chk(4'h0, 32'h100, 32'h0);
    @(posedge clk);
    raise_req <= 1'h1;
    @(posedge clk);
    raise_req <= 1'h0;
    cyc(5);
    chk(4'h0, 32'h200, 32'h200);
    wr(4'h4, 32'h100);
    check(s2p_ack, 32'h1);
    cyc(6);
    chk(4'h0, 32'h200, 32'h0);
    wr(4'h4, 32'h200);
    app <= 1'h1;
    for (int o = 0; o < 4; o++) begin
      for (int s = 0; s < 3; s++) begin
        wr(4'h8, {29'h0, o[1], o[0], 1'h1});
        @(posedge clk);
        por <= (s == 0);
        pri_rt <= (s == 1);
        sec_rt <= (s == 2);
        cyc(6);
        held = (s != 1) || (o != 2);
        dis = (s == 0) || (s == 2 && o[1]) || (s == 1 && o == 3);
        exp_irq += held;
        check(in_rst, held);
        @(posedge clk);
        {por, pri_rt, sec_rt} <= 3'h0;
        cyc(6);
        chk(4'h8, 32'h1, !dis);
        check(sec_en, !dis);
      end
    end
    check(n_irq, exp_irq);
    wr(4'h4, 32'h0);
    wr(4'h8, 32'h7);
    @(posedge clk);
    wdt <= 1'h1;
    cyc(6);
    chk(4'h0, 32'hC000, 32'hC000);
    check(sec_en, 32'h0);
    check(n_irq, exp_irq);
    @(posedge clk);
    wdt <= 1'h0;
    cyc(6);
    chk(4'h0, 32'hC000, 32'h4000);
    tally_and_finish();
  end
endmodule // testbench
